// ### dpc_map.vh
// Purpose: constants for the dual-port converter front end
// Assumes: 50 MHz mclk, register port with one-cycle read latency
// Notes: byte offsets on an 8-bit address, 16-bit data
`ifndef DPC_MAP_VH
`define DPC_MAP_VH

// register offsets
`define DPC_OFS_CTRL 8'h00
`define DPC_OFS_STATUS 8'h04
`define DPC_OFS_PERIOD 8'h08
`define DPC_OFS_CODE 8'h0C
`define DPC_OFS_DROPS 8'h10

// control fields and reset value
`define DPC_CTRL_OUT_EN 0
`define DPC_CTRL_FLUSH 1
`define DPC_CTRL_RESET 1'h1

// status fields
`define DPC_ST_LOCK 0
`define DPC_ST_ACTIVE 1
`define DPC_ST_FULL 2
`define DPC_ST_EMPTY 3
`define DPC_ST_SEL_LO 4
`define DPC_ST_SEL_HI 5
`define DPC_ST_LEVEL_LSB 8

// loop timing
`define DPC_PERIOD_W 16
`define DPC_LOCK_MATCHES 4'h4
`define DPC_LOCK_TOL 16'h0002
`define DPC_MCLK_MHZ 50

// code split into segment groups
`define DPC_UPPER_SEGS 31
`define DPC_MIDDLE_SEGS 15
`define DPC_ALL_SEGS 47

`endif

// ### dpc_fifo.v
// Purpose: word FIFO between the port capture and the output interleaver
// Assumes: single clock, synchronous flush
// Notes: read data is combinational from the head entry
`timescale 1ns/10ps

module dpc_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk,
	input wire resetn,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_push;
	wire do_pop;

	// honest full and empty from the occupancy count
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign level = count;
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	// storage array, written only on an accepted push
	always @(posedge mclk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				count <= count + 1'b1;
			end else if (do_pop && !do_push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // dpc_fifo

// ### dpc_core.v
// Purpose: dual-port capture, clock doubling interleaver and segment decode
// Assumes: all inputs synchronous to mclk; ext_clk is sampled as a level
// Notes: the doubled clock is emulated by a mid-period tick derived from
// the measured external period, so the mid point ignores duty cycle
`timescale 1ns/10ps
`include "dpc_map.vh"

// Summary of operation
// RULE_01: both ports are captured together on each external clock rising edge.
// RULE_02: an internal tick at twice the external rate drives latch and decode.
// RULE_03: multiplier mode is active whenever the multiplier supply pin is high.
// RULE_04: range selects pick prescaler 1, 2, 4 or 8, high select first.
// RULE_05: the source keeps its clock inside the band for the chosen setting.
// RULE_06: lock indicator shows phase detector result, high while locked.
// RULE_07: the source grounds the divider reset; it has no function here.
// RULE_08: below 6.25 MSPS the source disables the multiplier instead.
// RULE_09: five upper bits to 31 units, four to 15 sixteenths, lsb fraction.
// RULE_10: every segment is steered to exactly one of the two outputs.
// RULE_11: edge-triggered latches then segment decoding, at full rate.
// RULE_12: each rising edge moves the held second-port word to the output.
// RULE_13: half a period later the first-port word goes to the output.
// RULE_14: decoded segments are registered and switch together after a load.
module dpc_core #(
	parameter DATA_W = 10,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3,
	parameter PERIOD_W = `DPC_PERIOD_W
) (
	input wire mclk,
	input wire resetn,
	input wire ext_clk,
	input wire [DATA_W-1:0] first_port_word,
	input wire [DATA_W-1:0] second_port_word,
	input wire multiplier_supply_pin,
	input wire range_select_high,
	input wire range_select_low,
	input wire divider_reset,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	output reg lock_indicator,
	output reg capture_ready,
	output reg [`DPC_UPPER_SEGS-1:0] true_upper_seg,
	output reg [`DPC_MIDDLE_SEGS-1:0] true_middle_seg,
	output reg true_lsb_seg,
	output reg [`DPC_ALL_SEGS-1:0] complement_current_output,
	output reg [`DPC_ALL_SEGS-1:0] true_current_output,
	output reg seg_update
);
	// thermometer decode: bit i is set when value exceeds i
	function [`DPC_UPPER_SEGS-1:0] thermo;
		input [4:0] value;
		integer i;
		begin
			thermo = {`DPC_UPPER_SEGS{1'b0}};
			for (i = 0; i < `DPC_UPPER_SEGS; i = i + 1) begin
				thermo[i] = (value > i);
			end
		end
	endfunction

	// shared prescale ratio decode, high select is the first bit
	function [3:0] ratio_of;
		input [1:0] sel;
		begin
			case (sel)
			2'h0: ratio_of = 4'h1;
			2'h1: ratio_of = 4'h2;
			2'h2: ratio_of = 4'h4;
			2'h3: ratio_of = 4'h8;
			default: ratio_of = 4'h1;
			endcase
		end
	endfunction

	// control and status state
	reg out_enable;
	reg flush_pulse;
	reg ext_clk_q;
	reg [PERIOD_W-1:0] period_cnt;
	reg [PERIOD_W-1:0] period_meas;
	reg [PERIOD_W-1:0] span_acc;
	reg [PERIOD_W-1:0] span_prev;
	reg [3:0] edge_idx;
	reg [3:0] match_cnt;
	reg period_valid;
	reg [PERIOD_W-1:0] half_cnt;
	reg half_armed;
	reg [DATA_W-1:0] hold_first;
	reg [DATA_W-1:0] hold_second;
	reg hold_valid;
	reg [DATA_W-1:0] out_latch;
	reg latch_load;
	reg [15:0] drop_cnt;
	reg [1:0] range_sel;

	wire active;
	wire ext_rise;
	wire [1:0] sel_now;
	wire [3:0] ratio;
	wire [PERIOD_W-1:0] span_sum;
	wire [PERIOD_W-1:0] span_diff;
	wire span_close;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_pop;
	wire [2*DATA_W-1:0] fifo_out_data;
	wire [FIFO_AW:0] fifo_level;
	wire push_req;
	wire [`DPC_UPPER_SEGS-1:0] next_upper;
	wire [`DPC_UPPER_SEGS-1:0] mid_thermo;
	wire [`DPC_MIDDLE_SEGS-1:0] next_middle;
	wire [`DPC_ALL_SEGS-1:0] next_true;
	wire sel_ctrl;
	wire sel_status;
	wire sel_period;
	wire sel_code;
	wire sel_drops;

	// mode follows the supply pin; divider_reset is deliberately unused
	assign active = multiplier_supply_pin; // [RULE_03]
	assign ext_rise = ext_clk && !ext_clk_q;
	assign sel_now = {range_select_high, range_select_low};
	assign ratio = ratio_of(range_sel); // [RULE_04]
	assign span_sum = span_acc + period_cnt;
	assign span_diff = (span_sum > span_prev) ? span_sum - span_prev :
		span_prev - span_sum;
	assign span_close = (span_diff <= `DPC_LOCK_TOL);

	// both ports travel as one FIFO word, second port in the upper half
	assign push_req = active && ext_rise; // [RULE_01]
	assign fifo_pop = active && ext_rise && out_enable;

	dpc_fifo #(
		.WIDTH(2*DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.mclk(mclk),
		.resetn(resetn),
		.flush(flush_pulse),
		.in_valid(push_req),
		.in_ready(fifo_in_ready),
		.in_data({second_port_word, first_port_word}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// edge detect on the sampled external clock
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ext_clk_q <= 1'b0;
		end else begin
			ext_clk_q <= ext_clk;
		end
	end

	// period measurement and range controller phase comparison
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			period_cnt <= {PERIOD_W{1'b0}};
			period_meas <= {PERIOD_W{1'b0}};
			span_acc <= {PERIOD_W{1'b0}};
			span_prev <= {PERIOD_W{1'b0}};
			edge_idx <= 4'h0;
			match_cnt <= 4'h0;
			period_valid <= 1'b0;
			range_sel <= 2'h0;
			lock_indicator <= 1'b0;
		end else if (!active || range_sel != sel_now) begin
			// leaving the mode or changing range restarts acquisition
			period_cnt <= {PERIOD_W{1'b0}};
			span_acc <= {PERIOD_W{1'b0}};
			edge_idx <= 4'h0;
			match_cnt <= 4'h0;
			period_valid <= 1'b0;
			range_sel <= sel_now;
			lock_indicator <= 1'b0;
		end else if (ext_rise) begin
			period_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1};
			period_meas <= period_cnt;
			period_valid <= (period_cnt != {PERIOD_W{1'b0}});
			if (edge_idx == ratio - 1'b1) begin
				// compare span over one prescaled reference period
				edge_idx <= 4'h0;
				span_acc <= {PERIOD_W{1'b0}};
				span_prev <= span_sum;
				if (span_close && period_valid) begin
					if (match_cnt != `DPC_LOCK_MATCHES) begin
						match_cnt <= match_cnt + 1'b1;
					end
					lock_indicator <= (match_cnt == `DPC_LOCK_MATCHES); // [RULE_06]
				end else begin
					match_cnt <= 4'h0;
					lock_indicator <= 1'b0; // [RULE_06]
				end
			end else begin
				edge_idx <= edge_idx + 1'b1;
				span_acc <= span_sum;
			end
		end else if (period_cnt == {PERIOD_W{1'b1}}) begin
			// clock stopped: drop lock and forget the period
			period_valid <= 1'b0;
			match_cnt <= 4'h0;
			lock_indicator <= 1'b0;
		end else begin
			period_cnt <= period_cnt + 1'b1;
		end
	end

	// mid-period tick: the doubled clock's second edge in each period
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			half_cnt <= {PERIOD_W{1'b0}};
			half_armed <= 1'b0;
		end else if (!active) begin
			half_armed <= 1'b0;
		end else if (ext_rise) begin
			half_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1};
			half_armed <= period_valid; // [RULE_02]
		end else if (half_armed) begin
			if (half_cnt >= {1'b0, period_meas[PERIOD_W-1:1]}) begin
				half_armed <= 1'b0;
			end
			half_cnt <= half_cnt + 1'b1;
		end
	end

	// input hold latches and output latch interleave
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hold_first <= {DATA_W{1'b0}};
			hold_second <= {DATA_W{1'b0}};
			hold_valid <= 1'b0;
			out_latch <= {DATA_W{1'b0}};
			latch_load <= 1'b0;
		end else begin
			latch_load <= 1'b0;
			if (fifo_pop) begin
				if (hold_valid) begin
					out_latch <= hold_second; // [RULE_12]
					latch_load <= 1'b1;
				end
				hold_first <= fifo_out_data[DATA_W-1:0];
				hold_second <= fifo_out_data[2*DATA_W-1:DATA_W];
				hold_valid <= fifo_out_valid;
			end else if (half_armed && out_enable && hold_valid &&
				half_cnt >= {1'b0, period_meas[PERIOD_W-1:1]}) begin
				out_latch <= hold_first; // [RULE_13]
				latch_load <= 1'b1;
			end
		end
	end

	// segment decode feeding the switch registers
	assign next_upper = thermo(out_latch[9:5]); // [RULE_09]
	assign mid_thermo = thermo({1'b0, out_latch[4:1]});
	assign next_middle = mid_thermo[`DPC_MIDDLE_SEGS-1:0]; // [RULE_09]
	assign next_true = {next_upper, next_middle, out_latch[0]}; // [RULE_11]

	// all switches change together one edge after a latch load
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			true_upper_seg <= {`DPC_UPPER_SEGS{1'b0}};
			true_middle_seg <= {`DPC_MIDDLE_SEGS{1'b0}};
			true_lsb_seg <= 1'b0;
			true_current_output <= {`DPC_ALL_SEGS{1'b0}};
			complement_current_output <= {`DPC_ALL_SEGS{1'b1}};
			seg_update <= 1'b0;
		end else begin
			seg_update <= latch_load;
			if (latch_load) begin
				true_upper_seg <= next_upper; // [RULE_14]
				true_middle_seg <= next_middle; // [RULE_14]
				true_lsb_seg <= out_latch[0];
				true_current_output <= next_true; // [RULE_14]
				complement_current_output <= ~next_true; // [RULE_10]
			end
		end
	end

	// capture readiness and count of words lost to a full FIFO
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			capture_ready <= 1'b0;
			drop_cnt <= 16'h0000;
		end else begin
			capture_ready <= active && fifo_in_ready;
			if (push_req && !fifo_in_ready && drop_cnt != 16'hFFFF) begin
				drop_cnt <= drop_cnt + 1'b1;
			end
		end
	end

	// register port address decode
	assign sel_ctrl = (reg_addr == `DPC_OFS_CTRL);
	assign sel_status = (reg_addr == `DPC_OFS_STATUS);
	assign sel_period = (reg_addr == `DPC_OFS_PERIOD);
	assign sel_code = (reg_addr == `DPC_OFS_CODE);
	assign sel_drops = (reg_addr == `DPC_OFS_DROPS);

	// control register write; flush is a self-clearing strobe
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			out_enable <= `DPC_CTRL_RESET;
			flush_pulse <= 1'b0;
		end else begin
			flush_pulse <= 1'b0;
			if (reg_wr && sel_ctrl) begin
				out_enable <= reg_wdata[`DPC_CTRL_OUT_EN];
				flush_pulse <= reg_wdata[`DPC_CTRL_FLUSH];
			end
		end
	end

	// read data valid the cycle after the strobe, zero otherwise
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else if (!reg_rd) begin
			reg_rdata <= 16'h0000;
		end else if (sel_ctrl) begin
			reg_rdata <= {15'h0000, out_enable};
		end else if (sel_status) begin
			reg_rdata <= {{(8-FIFO_AW-1){1'b0}}, fifo_level, 2'h0,
				range_sel, !fifo_out_valid, !fifo_in_ready, active,
				lock_indicator};
		end else if (sel_period) begin
			reg_rdata <= period_meas[15:0];
		end else if (sel_code) begin
			reg_rdata <= {6'h00, out_latch};
		end else if (sel_drops) begin
			reg_rdata <= drop_cnt;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule // dpc_core

// ### dpc_core_properties.sv
// Purpose: port properties of the converter front end
// Assumes: one mclk domain, resetn active low
// Notes: bound to dpc_core after the module
`timescale 1ns/10ps
`include "dpc_map.vh"
module dpc_core_props (
	input wire mclk,
	input wire resetn,
	input wire multiplier_supply_pin,
	input wire range_select_high,
	input wire range_select_low,
	input wire lock_indicator,
	input wire capture_ready,
	input wire [`DPC_UPPER_SEGS-1:0] true_upper_seg,
	input wire [`DPC_MIDDLE_SEGS-1:0] true_middle_seg,
	input wire true_lsb_seg,
	input wire [`DPC_ALL_SEGS-1:0] complement_current_output,
	input wire [`DPC_ALL_SEGS-1:0] true_current_output,
	input wire seg_update
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// multiplier supply seen low on two samples
	sequence s_mode_off;
		!multiplier_supply_pin ##1 !multiplier_supply_pin;
	endsequence
	AST_COMPL: assert property (complement_current_output == ~true_current_output)
		else $error("complement output is not the inverse");
	AST_JOIN: assert property (true_current_output ==
		{true_upper_seg, true_middle_seg, true_lsb_seg})
		else $error("segment groups do not form the output");
	AST_SEG_HOLD: assert property ($changed(true_current_output) |-> seg_update)
		else $error("segments changed without update pulse");
	AST_UPD_PULSE: assert property (seg_update |=> !seg_update)
		else $error("update pulse longer than one cycle");
	AST_LOCK_OFF: assert property (s_mode_off |-> !lock_indicator)
		else $error("lock high with multiplier off");
	AST_READY_OFF: assert property (s_mode_off |-> !capture_ready)
		else $error("capture ready with multiplier off");
	AST_QUIET_OFF: assert property (s_mode_off ##1 !multiplier_supply_pin
		##1 !multiplier_supply_pin |-> !seg_update)
		else $error("segments update with multiplier off");
	AST_LOCK_SEL: assert property ($changed({range_select_high,
		range_select_low}) |-> ##[1:2] !lock_indicator)
		else $error("lock kept over a range change");
	AST_LOCK_RISE: assert property ($rose(lock_indicator) |->
		$past(multiplier_supply_pin))
		else $error("lock rose outside multiplier mode");
endmodule // dpc_core_props
bind dpc_core dpc_core_props i_dpc_core_props (.mclk(mclk), .resetn(resetn),
	.multiplier_supply_pin(multiplier_supply_pin),
	.range_select_high(range_select_high), .range_select_low(range_select_low),
	.lock_indicator(lock_indicator), .capture_ready(capture_ready),
	.true_upper_seg(true_upper_seg), .true_middle_seg(true_middle_seg),
	.true_lsb_seg(true_lsb_seg),
	.complement_current_output(complement_current_output),
	.true_current_output(true_current_output), .seg_update(seg_update));

// ### dpc_src.sv
// Purpose: external source driving both ports and the data clock
// Assumes: half period in mclk cycles, at least 2
// Notes: clock stands low and data lines wander while run is low
`timescale 1ns/10ps
module dpc_src (
	input wire mclk,
	input wire resetn,
	input wire run,
	input wire [7:0] half,
	input wire [9:0] word_a,
	input wire [9:0] word_b,
	output reg ext_clk,
	output reg [9:0] first_port_word,
	output reg [9:0] second_port_word
);
	reg [7:0] cnt;
	// data clock at the period the bench picks for the range
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 8'h00;
			ext_clk <= 1'b0;
			first_port_word <= 10'h000;
			second_port_word <= 10'h3FF;
		end else if (!run) begin
			cnt <= 8'h00;
			ext_clk <= 1'b0;
			first_port_word <= ~first_port_word; // idle lines never hold
			second_port_word <= ~second_port_word;
		end else if (cnt == half - 8'h01) begin
			cnt <= 8'h00;
			ext_clk <= ~ext_clk;
			// new words on the fall, steady across the next rise
			if (ext_clk) begin
				first_port_word <= word_a;
				second_port_word <= word_b;
			end
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule // dpc_src

// ### dual_port_dac_interface_pll_mode_bench.sv
// Purpose: self-checking bench for the converter front end
// Assumes: 50 MHz mclk, source model on the ports
// Notes: output codes are matched in order against captured pairs
`timescale 1ns/10ps
`include "dpc_map.vh"
module dual_port_dac_interface_pll_mode_bench;
	reg mclk, resetn = 1'b0, mps = 1'b1, sel_hi = 1'b0, sel_lo = 1'b0;
	reg run = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_q = 1'b0;
	reg [7:0] reg_addr = 8'h00, half = 8'h04;
	reg [15:0] reg_wdata = 16'h0000, lf = 16'h0006;
	reg [9:0] word_a = 10'h000, word_b = 10'h000;
	wire ext_clk, lock_indicator, capture_ready, true_lsb_seg, seg_update;
	wire [9:0] p1, p2;
	wire [15:0] reg_rdata;
	wire [30:0] up;
	wire [14:0] mid;
	wire [46:0] tco, cco;
	integer num_errors = 0, samples_checked = 0, cycles = 0, i, k, m;
	integer q[$];
	reg mon_on = 1'b0, synced = 1'b0;
	reg [9:0] code;
	dpc_core i_dpc_core (.mclk(mclk), .resetn(resetn), .ext_clk(ext_clk),
		.first_port_word(p1), .second_port_word(p2),
		.multiplier_supply_pin(mps), .range_select_high(sel_hi),
		.range_select_low(sel_lo), .divider_reset(1'b0),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.lock_indicator(lock_indicator), .capture_ready(capture_ready),
		.true_upper_seg(up), .true_middle_seg(mid),
		.true_lsb_seg(true_lsb_seg), .complement_current_output(cco),
		.true_current_output(tco), .seg_update(seg_update));
	dpc_src i_dpc_src (.mclk(mclk), .resetn(resetn), .run(run), .half(half),
		.word_a(word_a), .word_b(word_b), .ext_clk(ext_clk),
		.first_port_word(p1), .second_port_word(p2));
	function [15:0] lfsr(input [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input string n, input [46:0] e, input [46:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %s expected %0h seen %0h", n, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	task rdc(input string n, input [7:0] a, input [15:0] m, input [15:0] e);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 chk(n, e, reg_rdata & m);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// random words for the source
	always @(posedge mclk) begin
		lf <= lfsr(lf);
		word_a <= lf[9:0];
		word_b <= lf[15:6];
	end
	// watch the time; a run past the ceiling counts as a mismatch
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles > 20000) begin
			num_errors = num_errors + 1;
			finish_test;
		end
	end
	// record captured pairs, match the output stream
	always @(posedge mclk) begin
		ext_q <= ext_clk;
		if (mon_on && mps && ext_clk && !ext_q) begin
			q.push_back(p1);
			q.push_back(p2);
		end
		if (mon_on && seg_update) begin
			code = ($countones(up) << 5) + ($countones(mid) << 1) + true_lsb_seg;
			m = -1;
			if (!synced)
				foreach (q[j]) if (m < 0 && q[j] == code) m = j;
			if (m >= 0) begin
				synced = 1'b1;
				repeat (m + 1) void'(q.pop_front());
			end else if (synced) begin
				chk("code", q.size() ? q.pop_front() : -1, code);
			end
		end
	end
	// main sequence
	initial begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rdc("ctrl", `DPC_OFS_CTRL, 16'hFFFF, 16'h0001);
		wr(8'h20, 16'hFFFF);
		rdc("unmapped", 8'h20, 16'hFFFF, 16'h0000);
		$display("test registers done");
		for (i = 0; i < 4; i = i + 1) begin
			// reacquisition skips one mid-period load, so watch after lock
			mon_on = 1'b0;
			@(posedge mclk);
			{sel_hi, sel_lo} <= i[1:0];
			half <= 8'h04 + i[7:0];
			run <= 1'b1;
			k = 0;
			repeat (2) @(posedge mclk);
			while (lock_indicator !== 1'b1 && k < 4000) begin
				@(posedge mclk);
				k = k + 1;
			end
			#1 chk("lock", 1, lock_indicator);
			q.delete();
			synced = 1'b0;
			mon_on = 1'b1;
			rdc("status", `DPC_OFS_STATUS, 16'h0033, {10'h000, i[1:0], 4'h3});
			rdc("period", `DPC_OFS_PERIOD, 16'hFFFF, {7'h00, half, 1'b0});
			repeat (60) @(posedge mclk);
			#1 chk("stream", 1, synced);
		end
		$display("test ranges and stream done");
		mon_on = 1'b0;
		wr(`DPC_OFS_CTRL, 16'h0000);
		repeat (200) @(posedge mclk);
		#1 chk("ready", 0, capture_ready);
		rdc("full", `DPC_OFS_STATUS, 16'h0F04, 16'h0804);
		run <= 1'b0;
		wr(`DPC_OFS_CTRL, 16'h0003);
		rdc("empty", `DPC_OFS_STATUS, 16'h0F0C, 16'h0008);
		rdc("ctrl", `DPC_OFS_CTRL, 16'hFFFF, 16'h0001);
		$display("test stall and flush done");
		q.delete();
		synced = 1'b0;
		mon_on = 1'b1;
		run <= 1'b1;
		repeat (300) @(posedge mclk);
		mon_on = 1'b0;
		mps <= 1'b0; // source turns the multiplier off
		repeat (50) @(posedge mclk);
		#1 chk("lock off", 0, lock_indicator);
		chk("ready off", 0, capture_ready);
		chk("resumed", 1, synced);
		q.delete();
		synced = 1'b0;
		mps <= 1'b1;
		mon_on = 1'b1;
		repeat (300) @(posedge mclk);
		chk("restart", 1, synced);
		$display("test mode off done");
		finish_test;
	end
endmodule // dual_port_dac_interface_pll_mode_bench
